// ### bro_pkg.sv
// Constants, register map and state codes shared by the BCD reading output port.
// Assumes a 250 MHz system clock and a 32-bit APB register bus.
`default_nettype none
package bro_pkg;
    // Clock rate and print strobe width
    localparam int CLK_MHZ = 250;
    localparam int STROBE_US = 20;
    localparam int STROBE_CYCLES = STROBE_US * CLK_MHZ;
    localparam int STROBE_CNT_W = 16;

    // Display digits and remote programming lines
    localparam int NUM_DIGITS = 11;
    localparam int DIGIT_W = 4;
    localparam int BCD_W = NUM_DIGITS * DIGIT_W;
    localparam int REM_DATA_W = 22;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DIG_LO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DIG_HI = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_REM_DATA = 8'h14;

    // Control register fields
    localparam int CTRL_SHOW_PWR = 0;
    localparam int CTRL_FREQ_NEG = 1;
    localparam int CTRL_PWR_NEG = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Command register fields (write-only strobes)
    localparam int CMD_UPDATE = 0;
    localparam int CMD_REM_DONE = 1;

    // Digit register layout
    localparam int DIG_LO_N = 8;
    localparam int DIG_HI_W = BCD_W - 32;

    // Strobe generator states
    typedef enum logic [2:0] {
        SG_IDLE = 3'b001,
        SG_SETTLE = 3'b010,
        SG_PULSE = 3'b100
    } bro_strobe_e;
endpackage
`default_nettype wire

// ### bro_strobe_gen.sv
// Print strobe generator: one settle cycle, then an active-low pulse of fixed length.
// Assumes start is a one-cycle request given only while busy is low.
`timescale 1ns/1ns
`default_nettype none
module bro_strobe_gen
    import bro_pkg::*;
#(
    parameter int PULSE_CYCLES = STROBE_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic start,
    output logic busy,
    output var logic strobeN_q
);
    bro_strobe_e state_q, state_d;
    logic [STROBE_CNT_W-1:0] cnt_q, cnt_d;
    logic pulseEnd;

    // Last cycle of the low pulse
    assign pulseEnd = (cnt_q == STROBE_CNT_W'(PULSE_CYCLES - 1));
    assign busy = (state_q != SG_IDLE);

    // Settle one cycle so the digit lines are stable before the strobe falls
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SG_IDLE: begin
                if (start) begin
                    state_d = SG_SETTLE;
                end
            end
            SG_SETTLE: begin
                state_d = SG_PULSE;
                cnt_d = '0;
            end
            SG_PULSE: begin
                cnt_d = cnt_q + 1'b1;
                if (pulseEnd) begin
                    state_d = SG_IDLE;
                end
            end
            default: begin
                state_d = SG_IDLE;
            end
        endcase
    end

    // State, counter and registered strobe pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= SG_IDLE;
            cnt_q <= '0;
            strobeN_q <= 1'b1;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            strobeN_q <= (state_d != SG_PULSE);
        end
    end

    // Strobe is low exactly while in the pulse state
    a_strobe_low_pulse: assert property (@(posedge clk) disable iff (!rstn)
        (strobeN_q == (state_q != SG_PULSE)))
        else $error("print strobe level disagrees with pulse state");

    // Pulse ends only after the full width has been counted
    a_strobe_full_width: assert property (@(posedge clk) disable iff (!rstn)
        ($past(state_q) == SG_PULSE) && (state_q == SG_IDLE) |-> ($past(cnt_q) == STROBE_CNT_W'(PULSE_CYCLES - 1)))
        else $error("print strobe ended before its full width");
endmodule // bro_strobe_gen
`default_nettype wire

// ### bro_output_port.sv
// BCD reading output port with remote programming capture, reached over APB.
// Assumes all pins are synchronous to clk; the printer drives inhibit active high.
//
// Overview of operation
// - All eleven display digits appear at once on the port, four BCD lines each, plus one sign line.
// - Within each digit the lines A, B, C and D carry the weights 1, 2, 4 and 8.
// - An active-low print strobe of 20 us on its own line marks the digit data as valid.
// - While the readout asserts inhibit the digits and sign are held and not updated.
// - When only frequency is shown the sign line gives the polarity of the frequency.
// - When frequency and power are shown together the sign line gives the polarity of the power.
// - Every remote input is active low, so a grounded line is true and a floating one is false.
// - Remote control reaches all panel functions except power, sample rate, clear display and tests above 01.
// - A low remote enable moves control from the front panel to the remote connector.
// - Data accepted goes high while remote data is read and falls when the read cycle is complete.
// - The remote lines are program data while the program select line is low, function data when high.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module bro_output_port
    import bro_pkg::*;
#(
    parameter int PULSE_CYCLES = STROBE_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    input wire logic inhibit,
    output var logic [BCD_W-1:0] bcdDigits,
    output var logic signOut,
    output var logic printStrobeN,
    input wire logic remoteEnableN,
    input wire logic inputDataN,
    input wire logic programDataN,
    input wire logic [REM_DATA_W-1:0] remoteDataN,
    output var logic dataAccepted,
    output var logic remoteMode
);
    logic [2:0] ctrl_q;
    logic [BCD_W-1:0] digits_q;
    logic pend_q, pend_d;
    logic progFlag_q;
    logic [REM_DATA_W-1:0] remData_q;
    logic strobeBusy;

    // APB decode; zero wait states, answer prepared in the setup cycle
    wire setup = psel && !penable;
    wire wrEn = psel && penable && pready && pwrite && ce;
    wire hitCtrl = (paddr == OFS_CTRL);
    wire hitDigLo = (paddr == OFS_DIG_LO);
    wire hitDigHi = (paddr == OFS_DIG_HI);
    wire hitCmd = (paddr == OFS_CMD);
    wire hitStatus = (paddr == OFS_STATUS);
    wire hitRem = (paddr == OFS_REM_DATA);
    wire mapped = hitCtrl | hitDigLo | hitDigHi | hitCmd | hitStatus | hitRem;
    wire cmdUpdate = wrEn && hitCmd && pwdata[CMD_UPDATE];
    wire cmdRemDone = wrEn && hitCmd && pwdata[CMD_REM_DONE];
    wire [5:0] status = {progFlag_q, dataAccepted, remoteMode, strobeBusy, pend_q, inhibit};
    wire [31:0] rdMux = hitCtrl ? {29'h0, ctrl_q} :
                        hitDigLo ? digits_q[31:0] :
                        hitDigHi ? {{(32 - DIG_HI_W){1'b0}}, digits_q[BCD_W-1:32]} :
                        hitStatus ? {26'h0, status} :
                        hitRem ? {{(32 - REM_DATA_W){1'b0}}, remData_q} : 32'h0;

    // Reading update: only when not inhibited and the previous strobe is over
    wire loadEn = ce && pend_q && !inhibit && !strobeBusy;
    wire newSign = ctrl_q[CTRL_SHOW_PWR] ? ctrl_q[CTRL_PWR_NEG] : ctrl_q[CTRL_FREQ_NEG];
    // A software request in the load cycle stays pending, so it is never lost
    assign pend_d = cmdUpdate | (pend_q & !loadEn);

    // Remote read: the panel is locked out while remote enable is low
    wire remRead = ce && remoteMode && !inputDataN && !dataAccepted;

    // APB response registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rdMux : 32'h0;
        end
    end

    // Software-written registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RESET;
            digits_q <= '0;
            pend_q <= 1'b0;
        end else if (ce) begin
            pend_q <= pend_d;
            if (wrEn && hitCtrl) begin
                ctrl_q <= pwdata[2:0];
            end
            if (wrEn && hitDigLo) begin
                digits_q[31:0] <= pwdata;
            end
            if (wrEn && hitDigHi) begin
                digits_q[BCD_W-1:32] <= pwdata[DIG_HI_W-1:0];
            end
        end
    end

    // One digit per loop pass; bit 0 of each nibble is line A, weight 1
    for (genvar d = 0; d < NUM_DIGITS; d++) begin : g_digit
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                bcdDigits[d*DIGIT_W +: DIGIT_W] <= '0;
            end else if (loadEn) begin
                bcdDigits[d*DIGIT_W +: DIGIT_W] <= digits_q[d*DIGIT_W +: DIGIT_W];
            end
        end
    end

    // Sign line follows the value whose polarity is meaningful for the display mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            signOut <= 1'b0;
        end else if (loadEn) begin
            signOut <= newSign;
        end
    end

    // Remote side: inverted on capture so software sees true as one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            remoteMode <= 1'b0;
            dataAccepted <= 1'b0;
            progFlag_q <= 1'b0;
            remData_q <= '0;
        end else if (ce) begin
            remoteMode <= !remoteEnableN;
            if (remRead) begin
                dataAccepted <= 1'b1;
                progFlag_q <= !programDataN;
                remData_q <= ~remoteDataN;
            end else if (cmdRemDone) begin
                dataAccepted <= 1'b0;
            end
        end
    end

    // Strobe generator; its start coincides with the digit load
    bro_strobe_gen #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_strobe (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .start(loadEn),
        .busy(strobeBusy),
        .strobeN_q(printStrobeN)
    );

    a_digits_follow_load: assert property (@(posedge clk) disable iff (!rstn)
        $past(loadEn) |-> (bcdDigits == $past(digits_q)))
        else $error("digit lines do not match the loaded reading");

    a_digit_a_weight: assert property (@(posedge clk) disable iff (!rstn)
        $past(loadEn) |-> (bcdDigits[0] == $past(digits_q[0])) && (bcdDigits[BCD_W-1] == $past(digits_q[BCD_W-1])))
        else $error("digit line order is wrong");

    a_hold_inhibit: assert property (@(posedge clk) disable iff (!rstn)
        $past(inhibit) |-> ($stable(bcdDigits) && $stable(signOut)))
        else $error("outputs changed while inhibited");

    a_sign_freq: assert property (@(posedge clk) disable iff (!rstn)
        $past(loadEn) && !$past(ctrl_q[CTRL_SHOW_PWR]) |-> (signOut == $past(ctrl_q[CTRL_FREQ_NEG])))
        else $error("sign does not follow frequency");

    a_sign_power: assert property (@(posedge clk) disable iff (!rstn)
        $past(loadEn) && $past(ctrl_q[CTRL_SHOW_PWR]) |-> (signOut == $past(ctrl_q[CTRL_PWR_NEG])))
        else $error("sign does not follow power");

    a_remote_inverted: assert property (@(posedge clk) disable iff (!rstn)
        $rose(dataAccepted) |-> (remData_q == ~$past(remoteDataN)))
        else $error("remote data not inverted on capture");

    a_remote_mode: assert property (@(posedge clk) disable iff (!rstn)
        $past(ce) |-> (remoteMode == !$past(remoteEnableN)))
        else $error("remote mode does not follow remote enable");

    a_accept_cause: assert property (@(posedge clk) disable iff (!rstn)
        $rose(dataAccepted) |-> ($past(remoteMode) && !$past(inputDataN)))
        else $error("data accepted rose without a remote read");

    a_program_select: assert property (@(posedge clk) disable iff (!rstn)
        $rose(dataAccepted) |-> (progFlag_q == !$past(programDataN)))
        else $error("program flag does not match select line");

    a_strobe_settled: assert property (@(posedge clk) disable iff (!rstn)
        $fell(printStrobeN) |-> ($stable(bcdDigits) && $stable(signOut) && !$past(loadEn)))
        else $error("strobe fell while outputs were changing");
endmodule // bro_output_port
`default_nettype wire

// ### bro_readout_model.sv
// Printer and remote controller model facing the BCD reading output port.
// Assumes the port clock; the testbench steers it through hold, go, prog and word.
`timescale 1ns/1ns
`default_nettype none
module bro_readout_model
    import bro_pkg::*;
(
    input wire logic clk,
    input wire logic printStrobeN,
    input wire logic dataAccepted,
    input wire logic hold,
    input wire logic go,
    input wire logic prog,
    input wire logic [REM_DATA_W-1:0] word,
    output logic inhibit,
    output logic remoteEnableN,
    output logic inputDataN,
    output logic programDataN,
    output logic [REM_DATA_W-1:0] remoteDataN,
    output logic done,
    output int strobes,
    output int lowLen
);
    int cnt;
    logic prevN;
    // Released remote lines sit high through their pull-ups
    initial begin
        inhibit = 1'b0;
        done = 1'b0;
        strobes = 0;
        lowLen = 0;
        cnt = 0;
        prevN = 1'b1;
        {remoteEnableN, inputDataN, programDataN} = 3'h7;
        remoteDataN = '1;
    end
    // Printer side: inhibit on request, count strobes and measure their width
    always @(posedge clk) begin
        inhibit <= hold;
        prevN <= printStrobeN;
        if (!printStrobeN) begin
            cnt <= cnt + 1;
        end else if (!prevN) begin
            lowLen <= cnt;
            strobes <= strobes + 1;
            cnt <= 0;
        end
    end
    // Controller holds its lines only until the port acknowledges, then lets them float
    always @(posedge clk) begin
        remoteEnableN <= !go;
        if (!go) begin
            done <= 1'b0;
        end else if (dataAccepted) begin
            done <= 1'b1;
        end
        if (!go || done || dataAccepted) begin
            inputDataN <= 1'b1;
            programDataN <= 1'b1;
            remoteDataN <= '1;
        end else begin
            inputDataN <= 1'b0;
            programDataN <= !prog;
            remoteDataN <= ~word;
        end
    end
endmodule // bro_readout_model
`default_nettype wire

// ### tb_bcd_reading_output_port.sv
// Self-checking bench for the BCD reading output port with printer and controller model.
// Assumes the port answers APB in one access cycle and uses a shortened strobe.
`timescale 1ns/1ns
`default_nettype none
module tb_bcd_reading_output_port
    import bro_pkg::*;
;
    localparam int PC = 8;
    logic clk, rstn, ce, psel, penable, pwrite, pready, pslverr, signOut, printStrobeN;
    logic inhibit, remoteEnableN, inputDataN, programDataN, dataAccepted, remoteMode;
    logic hold, go, prog, done, rerr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [BCD_W-1:0] bcdDigits;
    logic [REM_DATA_W-1:0] remoteDataN, word;
    int strobes, lowLen, mismatches, checked;

    bro_output_port #(.PULSE_CYCLES(PC)) i_bro_output_port (.clk(clk), .rstn(rstn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .inhibit(inhibit),
        .bcdDigits(bcdDigits), .signOut(signOut), .printStrobeN(printStrobeN),
        .remoteEnableN(remoteEnableN), .inputDataN(inputDataN), .programDataN(programDataN),
        .remoteDataN(remoteDataN), .dataAccepted(dataAccepted), .remoteMode(remoteMode));
    bro_readout_model i_bro_readout_model (.clk(clk), .printStrobeN(printStrobeN),
        .dataAccepted(dataAccepted), .hold(hold), .go(go), .prog(prog), .word(word),
        .inhibit(inhibit), .remoteEnableN(remoteEnableN), .inputDataN(inputDataN),
        .programDataN(programDataN), .remoteDataN(remoteDataN), .done(done),
        .strobes(strobes), .lowLen(lowLen));

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic timeout();
        mismatches++;
        give_verdict();
    endtask
    // One APB transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) timeout();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait for a print strobe, judge the digits while it is low, then its width
    task automatic print_seen(input logic [BCD_W-1:0] d);
        int n;
        n = 0;
        while (printStrobeN !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40) timeout();
        chk(bcdDigits, d);
        n = 0;
        while (printStrobeN !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40) timeout();
        repeat (3) @(posedge clk);
        chk(lowLen, PC);
    endtask

    task automatic test_update();
        int n0;
        apb(1'b0, 8'h18, 32'h0);
        chk({rerr, rdat}, 33'h100000000);
        apb(1'b1, OFS_DIG_LO, 32'h76543210);
        apb(1'b1, OFS_DIG_HI, 32'h198);
        apb(1'b1, OFS_CTRL, 32'h2);
        n0 = strobes;
        apb(1'b1, OFS_CMD, 32'h1);
        print_seen(44'h19876543210);
        chk(bcdDigits[15:12], 4'h3);
        chk(signOut, 1'b1);
        chk(strobes, n0 + 1);
        $display("test update done");
    endtask
    task automatic test_sign();
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, OFS_CTRL, i);
            apb(1'b1, OFS_CMD, 32'h1);
            print_seen(44'h19876543210);
            chk(signOut, i[0] ? i[2] : i[1]);
        end
        $display("test sign done");
    endtask
    task automatic test_inhibit();
        int n0;
        hold <= 1'b1;
        repeat (2) @(posedge clk);
        n0 = strobes;
        apb(1'b1, OFS_DIG_LO, 32'h99999999);
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b1, OFS_CMD, 32'h1);
        repeat (30) @(posedge clk);
        chk(bcdDigits, 44'h19876543210);
        chk(strobes, n0);
        hold <= 1'b0;
        print_seen(44'h19899999999);
        repeat (20) @(posedge clk);
        chk(strobes, n0 + 1);
        $display("test inhibit done");
    endtask
    // Clock enable low must freeze a pending update; it prints once enable returns
    task automatic test_freeze();
        int n0;
        apb(1'b1, OFS_DIG_LO, 32'h01234567);
        n0 = strobes;
        apb(1'b1, OFS_CMD, 32'h1);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        chk(bcdDigits, 44'h19899999999);
        chk({printStrobeN, dataAccepted}, 2'h2);
        chk(strobes, n0);
        ce <= 1'b1;
        print_seen(44'h19801234567);
        chk(strobes, n0 + 1);
        $display("test freeze done");
    endtask
    task automatic test_remote();
        int n;
        for (int p = 0; p < 2; p++) begin
            word <= 22'h2a5c3f ^ 22'(p);
            prog <= p[0];
            go <= 1'b1;
            n = 0;
            while (dataAccepted !== 1'b1 && n < 20) begin
                @(posedge clk);
                n++;
            end
            if (n >= 20) timeout();
            chk(remoteMode, 1'b1);
            apb(1'b0, OFS_REM_DATA, 32'h0);
            chk({rerr, rdat}, {1'b0, 32'h2a5c3f ^ p});
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(rdat[5], p[0]);
            apb(1'b1, OFS_CMD, 32'h2);
            repeat (2) @(posedge clk);
            chk(dataAccepted, 1'b0);
            go <= 1'b0;
            repeat (3) @(posedge clk);
            chk(remoteMode, 1'b0);
        end
        $display("test remote done");
    endtask

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Reset, then the scenarios in turn
    initial begin
        mismatches = 0;
        checked = 0;
        rstn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, hold, go, prog} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        word = 22'h0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        test_update();
        test_sign();
        test_inhibit();
        test_freeze();
        test_remote();
        give_verdict();
    end
endmodule // tb_bcd_reading_output_port
`default_nettype wire
